/* core/rpes_pkg.sv */
// Constants, types and register map of the packet event source block.
package rpes_pkg;
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_NS = 25;
    localparam int RXLEN1_US = 80;
    localparam int RXLEN2_US = 160;
    localparam int RF_WAKE_US = 210;
    localparam int AVG_US = 16;
    localparam int BIT_NS = 10000;
    localparam int RXLEN1_CYC = (RXLEN1_US * 1000) / CLK_NS;
    localparam int RXLEN2_CYC = (RXLEN2_US * 1000) / CLK_NS;
    localparam int RF_WAKE_CYC = (RF_WAKE_US * 1000) / CLK_NS;
    localparam int AVG_CYC = (AVG_US * 1000) / CLK_NS;
    localparam int BIT_CYC = BIT_NS / CLK_NS;
    localparam int TX_EXTRA_BITS = 3;
    // ****************************************************
    // Register indexes; byte address is four times the index
    // ****************************************************
    localparam logic [7:0] IDX_DIO = 8'h0c;
    localparam logic [7:0] IDX_GTCLK = 8'h33;
    localparam logic [7:0] IDX_GT1 = 8'h34;
    localparam logic [7:0] IDX_GT2 = 8'h35;
    localparam logic [7:0] IDX_LENH = 8'h7a;
    localparam logic [7:0] IDX_LENL = 8'h7b;
    localparam logic [7:0] IDX_STAT = 8'h40;
    localparam logic [7:0] IDX_MASK = 8'h41;
    localparam logic [7:0] IDX_CTRL = 8'h42;
    localparam logic [7:0] IDX_CCA = 8'h43;
    localparam logic [7:0] IDX_NONE = 8'hff;
    // ****************************************************
    // Fields and event positions
    // ****************************************************
    localparam int DIO_SEL_LSB = 6;
    localparam int CTRL_DIV_EN = 0;
    localparam int CTRL_LEN2 = 1;
    localparam int CTRL_IDLE_MODE = 2;
    localparam int CTRL_CCA_GO = 3;
    localparam int CTRL_GT1_GO = 4;
    localparam int CTRL_GT2_GO = 5;
    localparam int CTRL_CCA_RES = 8;
    localparam int EV_DIV = 10;
    localparam int EV_RXLEN = 11;
    localparam int EV_SYNC = 13;
    localparam int EV_FIELD = 14;
    localparam int EV_SYNCERR = 15;
    localparam int EV_TXDONE = 16;
    localparam int EV_TXACC = 17;
    localparam int EV_CCA = 18;
    localparam int EV_TXLEN = 19;
    localparam int EV_FIFOERR = 20;
    localparam int EV_GT1 = 22;
    localparam logic [23:0] EV_IMPL = 24'hdfec00;
    localparam logic [10:0] MAX_LEN = 11'h7ff;
    localparam logic [7:0] RST_8 = 8'h00;

    typedef logic [23:0] rpes_ev_t;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_FIRST = 2'b01,
        PH_SECOND = 2'b11
    } rpes_ph_e;
    typedef struct packed {
        logic sync_det;
        logic rx_active;
        logic rx_len_bad;
        logic field_done;
        logic sync_lost;
        logic tx_on;
        logic tx_full_len;
        logic tx_wr_nospace;
        logic tx_add_ovf;
        logic tx_underrun;
        logic cca_busy;
    } rpes_rad_s;
endpackage

/* core/rpes_top.sv */
// Interrupt events 10 to 23 of the packet handler with an AHB-Lite slave.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Behaviour
// - diversity event on sync word when enabled
// - RX length error 80/160us after sync
// - field check event on match or mismatch
// - sync error only when io select 00/11
// - TX done: wake + length bits + 3 bits
// - TX accept event on full-length FIFO write
// - CCA done after (avg + idle wait) periods
// - idle mode busy: only avg periods
// - averaging period is 16us
// - TX length checked on length register write
// - FIFO error on no-space, overflow, underrun
// - timer 1 after divider times interval
// - timer 2 after shared divider times interval
// - events latch regardless of mask
// - clearing CCA event clears CCA result
module rpes_top import rpes_pkg::*; #(
    parameter int RXL2_CYC = RXLEN2_CYC,
    parameter int WAKE_CYC = RF_WAKE_CYC
) (
    input logic sys_clk, // 40 MHz clock
    input logic rst_b, // async reset, low
    input logic hsel, // slave select
    input logic [31:0] haddr, // byte address
    input logic [1:0] htrans, // transfer type
    input logic hwrite, // write when high
    input logic [2:0] hsize, // word only
    input logic [31:0] hwdata, // write data
    input logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always OKAY
    input rpes_rad_s rad, // radio datapath events
    output logic irq, // level interrupt
    output logic cca_result // last CCA was busy
);
    // ****************************************************
    // Bus slave
    // ****************************************************
    function automatic logic [7:0] reg_idx(input logic [31:0] a);
        reg_idx = (a[31:10] == 22'h0) ? a[9:2] : IDX_NONE;
    endfunction

    logic addr_ok;
    logic ap_wr;
    logic [7:0] ap_idx;
    logic [7:0] dio_cfg, gt_div, len_h, len_l, cca_ed, cca_wait;
    logic [7:0] gt_ivl [2];
    logic [23:0] status, mask;
    logic div_en, len2, idle_mode, len_chk, cca_go;
    logic [1:0] gt_go, gt_done;
    logic [31:0] rd_val;
    logic [10:0] tx_len;
    logic rd_stat;
    rpes_ev_t ev;

    assign addr_ok = hsel & hready & htrans[1];
    assign rd_stat = addr_ok & ~hwrite & (reg_idx(haddr) == IDX_STAT);
    assign tx_len = {len_h[2:0], len_l};

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ap_wr <= 1'b0;
            ap_idx <= IDX_NONE;
        end else begin
            ap_wr <= addr_ok & hwrite;
            ap_idx <= reg_idx(haddr);
        end
    end

    always_comb begin
        rd_val = 32'h0;
        unique case (reg_idx(haddr))
            IDX_DIO: rd_val[7:0] = dio_cfg;
            IDX_GTCLK: rd_val[7:0] = gt_div;
            IDX_GT1: rd_val[7:0] = gt_ivl[0];
            IDX_GT2: rd_val[7:0] = gt_ivl[1];
            IDX_LENH: rd_val[7:0] = len_h;
            IDX_LENL: rd_val[7:0] = len_l;
            IDX_STAT: rd_val[23:0] = status;
            IDX_MASK: rd_val[23:0] = mask;
            IDX_CTRL: rd_val[CTRL_CCA_RES:0] = {cca_result, 5'h0,
                idle_mode, len2, div_en};
            IDX_CCA: rd_val[15:0] = {cca_wait, cca_ed};
            default: rd_val = 32'h0;
        endcase
    end

    // Zero wait states: read data is sampled in the address phase.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= (addr_ok & ~hwrite) ? rd_val : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dio_cfg <= RST_8;
            gt_div <= RST_8;
            gt_ivl[0] <= RST_8;
            gt_ivl[1] <= RST_8;
            len_h <= RST_8;
            len_l <= RST_8;
            cca_ed <= RST_8;
            cca_wait <= RST_8;
            mask <= 24'h0;
            div_en <= 1'b0;
            len2 <= 1'b0;
            idle_mode <= 1'b0;
        end else if (ap_wr) begin
            unique case (ap_idx)
                IDX_DIO: dio_cfg <= hwdata[7:0];
                IDX_GTCLK: gt_div <= hwdata[7:0];
                IDX_GT1: gt_ivl[0] <= hwdata[7:0];
                IDX_GT2: gt_ivl[1] <= hwdata[7:0];
                IDX_LENH: len_h <= hwdata[7:0];
                IDX_LENL: len_l <= hwdata[7:0];
                IDX_MASK: mask <= hwdata[23:0] & EV_IMPL;
                IDX_CTRL: begin
                    div_en <= hwdata[CTRL_DIV_EN];
                    len2 <= hwdata[CTRL_LEN2];
                    idle_mode <= hwdata[CTRL_IDLE_MODE];
                end
                IDX_CCA: begin
                    cca_ed <= hwdata[7:0];
                    cca_wait <= hwdata[15:8];
                end
                default: ;
            endcase
        end
    end

    // Start bits are write-one pulses; they never read back.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cca_go <= 1'b0;
            gt_go <= 2'b00;
            len_chk <= 1'b0;
        end else begin
            cca_go <= ap_wr & (ap_idx == IDX_CTRL) & hwdata[CTRL_CCA_GO];
            gt_go <= (ap_wr & (ap_idx == IDX_CTRL)) ?
                hwdata[CTRL_GT2_GO:CTRL_GT1_GO] : 2'b00;
            len_chk <= ap_wr & ((ap_idx == IDX_LENH) |
                (ap_idx == IDX_LENL));
        end
    end

    // ****************************************************
    // Receive side timing
    // ****************************************************
    logic [12:0] rxl_cnt;
    logic rxl_run, rxl_done, in_sync;
    logic [1:0] rx_sel;
    assign rx_sel = dio_cfg[DIO_SEL_LSB+1:DIO_SEL_LSB];

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rxl_cnt <= 13'h0;
            rxl_run <= 1'b0;
            rxl_done <= 1'b0;
        end else begin
            rxl_done <= 1'b0;
            if (rad.sync_det) begin
                rxl_run <= 1'b1;
                rxl_cnt <= 13'h1;
            end else if (rxl_run) begin
                rxl_cnt <= rxl_cnt + 13'h1;
                if (rxl_cnt == (len2 ? 13'(RXL2_CYC) :
                    13'(RXLEN1_CYC))) begin
                    rxl_run <= 1'b0;
                    rxl_done <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_sync <= 1'b0;
        end else begin
            in_sync <= rad.sync_det | (in_sync & rad.rx_active);
        end
    end

    // ****************************************************
    // Transmit completion: wake-up, then length bits plus three
    // ****************************************************
    rpes_ph_e tx_ph;
    logic [13:0] tx_cyc;
    logic [14:0] tx_bits;
    logic tx_done;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_ph <= PH_IDLE;
            tx_cyc <= 14'h0;
            tx_bits <= 15'h0;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            tx_cyc <= tx_cyc + 14'h1;
            unique case (tx_ph)
                PH_IDLE: begin
                    tx_cyc <= 14'h1;
                    if (rad.tx_on) begin
                        tx_ph <= PH_FIRST;
                    end
                end
                PH_FIRST: begin
                    if (tx_cyc == 14'(WAKE_CYC)) begin
                        tx_ph <= PH_SECOND;
                        tx_cyc <= 14'h1;
                        tx_bits <= {1'b0, tx_len, 3'b000} +
                            15'(TX_EXTRA_BITS);
                    end
                end
                PH_SECOND: begin
                    if (tx_cyc == 14'(BIT_CYC)) begin
                        tx_cyc <= 14'h1;
                        tx_bits <= tx_bits - 15'h1;
                        if (tx_bits == 15'h1) begin
                            tx_ph <= PH_IDLE;
                            tx_done <= 1'b1;
                        end
                    end
                end
                default: tx_ph <= PH_IDLE;
            endcase
        end
    end

    // ****************************************************
    // CCA: averaging periods, then optional idle-wait periods
    // ****************************************************
    rpes_ph_e cca_ph;
    logic [9:0] avg_cyc;
    logic [7:0] per_cnt;
    logic cca_done, per_end;
    assign per_end = (avg_cyc == 10'(AVG_CYC));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cca_ph <= PH_IDLE;
            avg_cyc <= 10'h0;
            per_cnt <= 8'h0;
            cca_done <= 1'b0;
            cca_result <= 1'b0;
        end else begin
            cca_done <= 1'b0;
            avg_cyc <= per_end ? 10'h1 : avg_cyc + 10'h1;
            // A result whose event survives the read is kept with it.
            if (rd_stat & status[EV_CCA] & ~cca_done) begin
                cca_result <= 1'b0;
            end
            unique case (cca_ph)
                PH_IDLE: begin
                    avg_cyc <= 10'h1;
                    per_cnt <= 8'h1;
                    if (cca_go) begin
                        cca_ph <= PH_FIRST;
                    end
                end
                PH_FIRST: if (per_end) begin
                    per_cnt <= per_cnt + 8'h1;
                    if (per_cnt >= cca_ed) begin
                        per_cnt <= 8'h1;
                        if (idle_mode & rad.cca_busy) begin
                            cca_ph <= PH_IDLE;
                            cca_done <= 1'b1;
                            cca_result <= 1'b1;
                        end else if (cca_wait == 8'h0) begin
                            cca_ph <= PH_IDLE;
                            cca_done <= 1'b1;
                            cca_result <= rad.cca_busy;
                        end else begin
                            cca_ph <= PH_SECOND;
                        end
                    end
                end
                PH_SECOND: if (per_end) begin
                    per_cnt <= per_cnt + 8'h1;
                    if (per_cnt >= cca_wait) begin
                        cca_ph <= PH_IDLE;
                        cca_done <= 1'b1;
                        cca_result <= rad.cca_busy;
                    end
                end
                default: cca_ph <= PH_IDLE;
            endcase
        end
    end

    // ****************************************************
    // General purpose timers on the shared divider
    // ****************************************************
    for (genvar g = 0; g < 2; g++) begin : gen_gt
        logic [7:0] pre, ivl;
        logic run;
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                pre <= 8'h0;
                ivl <= 8'h0;
                run <= 1'b0;
                gt_done[g] <= 1'b0;
            end else begin
                gt_done[g] <= 1'b0;
                if (gt_go[g]) begin
                    run <= 1'b1;
                    pre <= 8'h1;
                    ivl <= 8'h1;
                end else if (run) begin
                    pre <= pre + 8'h1;
                    if (pre >= gt_div) begin
                        pre <= 8'h1;
                        ivl <= ivl + 8'h1;
                        if (ivl >= gt_ivl[g]) begin
                            run <= 1'b0;
                            gt_done[g] <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // ****************************************************
    // Sticky status and interrupt
    // ****************************************************
    always_comb begin
        ev = 24'h0;
        ev[EV_DIV] = rad.sync_det & div_en;
        ev[EV_RXLEN] = rxl_done & rad.rx_len_bad;
        ev[EV_SYNC] = rad.sync_det;
        ev[EV_FIELD] = rad.field_done;
        ev[EV_SYNCERR] = rad.sync_lost & in_sync &
            (rx_sel == 2'b00 | rx_sel == 2'b11);
        ev[EV_TXDONE] = tx_done;
        ev[EV_TXACC] = rad.tx_full_len;
        ev[EV_CCA] = cca_done;
        ev[EV_TXLEN] = len_chk &
            (tx_len == 11'h0 | len_h[7:3] != 5'h0 |
            tx_len > MAX_LEN);
        ev[EV_FIFOERR] = rad.tx_wr_nospace | rad.tx_add_ovf |
            rad.tx_underrun;
        ev[EV_GT1+1:EV_GT1] = gt_done;
    end

    // A read clears status, but an event in the same cycle survives.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= 24'h0;
            irq <= 1'b0;
        end else begin
            status <= ((rd_stat ? 24'h0 : status) | ev) & EV_IMPL;
            irq <= |(status & mask);
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_div_event: assert property (rad.sync_det && div_en |=>
        status[EV_DIV]) else $error("diversity event missing");
    chk_sync_event: assert property (rad.sync_det |=>
        status[EV_SYNC]) else $error("sync event missing");
    chk_field_event: assert property (rad.field_done |=>
        status[EV_FIELD]) else $error("field event missing");
    chk_syncerr_sel: assert property ($rose(status[EV_SYNCERR]) |->
        $past(rx_sel) inside {2'b00, 2'b11}) else
        $error("sync error with wrong io select");
    chk_fifo_err: assert property (rad.tx_underrun |=>
        status[EV_FIFOERR]) else $error("FIFO error missing");
    chk_tx_accept: assert property (rad.tx_full_len |=>
        status[EV_TXACC]) else $error("TX accept missing");
    chk_rsvd_zero: assert property (status[12] == 1'b0 &&
        status[21] == 1'b0) else $error("reserved bit set");
    chk_irq_mask: assert property (##1 irq ==
        $past(|(status & mask))) else $error("irq mismatch");
    chk_cca_clear: assert property (rd_stat && status[EV_CCA] &&
        !cca_done ##1 !cca_done |-> !cca_result) else
        $error("CCA result kept");
    chk_cca_busy: assert property (cca_ph == PH_FIRST && per_end &&
        per_cnt >= cca_ed && idle_mode && rad.cca_busy |=>
        cca_done && cca_ph == PH_IDLE) else $error("busy CCA late");
    chk_len_event: assert property (len_chk && tx_len == 11'h0 |=>
        status[EV_TXLEN]) else $error("length error missing");
    chk_tx_wake: assert property ($rose(tx_ph == PH_SECOND) |->
        $past(tx_cyc) == 14'(WAKE_CYC)) else $error("wake time wrong");

    cov_cca_done: cover property (cca_done && !cca_result);
    cov_tx_done: cover property (tx_done);
    cov_gt_both: cover property (gt_done == 2'b11);
    cov_irq_rise: cover property ($rose(irq));
endmodule

/* tb/rpes_radio_model.sv */
// Behavioural radio datapath that feeds event pulses and levels.
`timescale 1ns/10ps
module rpes_radio_model import rpes_pkg::*; (
    input wire logic sys_clk, // 40 MHz clock
    output rpes_rad_s rad // radio datapath events
);
    initial begin
        rad = '0;
    end

    // Pulses last exactly one cycle so that a held bit is never counted twice.
    task automatic pulse(input int b);
        rad[b] <= 1'b1;
        @(posedge sys_clk);
        rad[b] <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic level(input int b, input logic v);
        rad[b] <= v;
        @(posedge sys_clk);
    endtask
endmodule

/* tb/test_rpes_top.sv */
// Self-checking testbench of the packet event source block.
`timescale 1ns/10ps
module test_rpes_top import rpes_pkg::*;;
    localparam int B_SYNC = 10;
    localparam int B_ACT = 9;
    localparam int B_LBAD = 8;
    localparam int B_FLD = 7;
    localparam int B_LOST = 6;
    localparam int B_TXON = 5;
    localparam int B_FULL = 4;
    localparam int B_BUSY = 0;
    localparam int WAKE = 50;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic cca_result;
    rpes_rad_s rad;
    int fail_count = 0;
    int compares = 0;
    logic [31:0] rv;

    always #12.5 sys_clk = ~sys_clk;

    rpes_radio_model i_rpes_radio_model (.sys_clk(sys_clk), .rad(rad));

    rpes_top #(.RXL2_CYC(40), .WAKE_CYC(WAKE)) i_rpes_top (
        .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rad(rad), .irq(irq), .cca_result(cca_result));

    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, exp, input string what);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what,
                seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Waits for hready at a rising edge; a hung slave ends the run.
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t bus never ready", $time);
            complete_run();
        end
    endtask

    task automatic xfer(input logic [7:0] idx, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0, "response");
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(idx, 1'b1, d, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e,
                          input string what);
        logic [31:0] d;
        xfer(idx, 1'b0, 32'h0, d);
        check(d, e, what);
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        logic [7:0] regs [6];
        regs = '{IDX_DIO, IDX_GTCLK, IDX_GT1, IDX_GT2, IDX_LENH, IDX_LENL};
        cyc(20);
        rst_b <= 1'b1;
        cyc(1);
        rd_chk(IDX_STAT, 32'h0, "status reset");
        for (int i = 0; i < 6; i++) rd_chk(regs[i], 32'h0, "reg reset");
        for (int i = 0; i < 6; i++) wr(regs[i], 32'ha5);
        for (int i = 0; i < 6; i++) rd_chk(regs[i], 32'ha5, "reg rw");
        wr(IDX_NONE, 32'h5a);
        rd_chk(IDX_NONE, 32'h0, "unmapped");
        cyc(2);
        rd_chk(IDX_STAT, 32'h80000, "length error");
        $display("test registers done");

        // A masked event is held and shows as soon as it is unmasked.
        i_rpes_radio_model.pulse(B_FLD);
        cyc(4);
        check({31'h0, irq}, 32'h0, "irq masked");
        wr(IDX_MASK, 32'h4000);
        cyc(3);
        check({31'h0, irq}, 32'h1, "irq unmasked");
        rd_chk(IDX_MASK, 32'h4000, "mask rw");
        rd_chk(IDX_STAT, 32'h4000, "field check");
        cyc(3);
        check({31'h0, irq}, 32'h0, "irq cleared");
        $display("test mask done");

        wr(IDX_DIO, 32'h0);
        wr(IDX_CTRL, 32'h3);
        i_rpes_radio_model.level(B_ACT, 1'b1);
        i_rpes_radio_model.level(B_LBAD, 1'b1);
        i_rpes_radio_model.pulse(B_SYNC);
        cyc(20);
        rd_chk(IDX_STAT, 32'h2400, "sync diversity");
        cyc(40);
        rd_chk(IDX_STAT, 32'h800, "rx length");
        i_rpes_radio_model.level(B_LBAD, 1'b0);
        wr(IDX_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_DIO, i << 6);
            i_rpes_radio_model.pulse(B_SYNC);
            i_rpes_radio_model.pulse(B_LOST);
            cyc(2);
            rd_chk(IDX_STAT, (i == 0 || i == 3) ? 32'ha000 : 32'h2000,
                "sync loss");
        end
        i_rpes_radio_model.level(B_LBAD, 1'b1);
        i_rpes_radio_model.pulse(B_SYNC);
        cyc(3100);
        rd_chk(IDX_STAT, 32'h2000, "one byte early");
        cyc(150);
        rd_chk(IDX_STAT, 32'h800, "one byte length");
        i_rpes_radio_model.level(B_LBAD, 1'b0);
        $display("test receive done");

        wr(IDX_LENH, 32'h0);
        wr(IDX_LENL, 32'h1);
        i_rpes_radio_model.pulse(B_FULL);
        cyc(2);
        rd_chk(IDX_STAT, 32'h20000, "tx accept");
        i_rpes_radio_model.pulse(B_TXON);
        cyc(WAKE + 11 * 400 - 100);
        rd_chk(IDX_STAT, 32'h0, "tx early");
        cyc(150);
        rd_chk(IDX_STAT, 32'h10000, "tx done");
        wr(IDX_LENL, 32'h0);
        cyc(2);
        rd_chk(IDX_STAT, 32'h80000, "zero length");
        for (int b = 3; b >= 1; b--) begin
            i_rpes_radio_model.pulse(b);
            cyc(2);
            rd_chk(IDX_STAT, 32'h100000, "fifo error");
        end
        $display("test transmit done");

        wr(IDX_CCA, 32'h0101);
        rd_chk(IDX_CCA, 32'h0101, "cca settings");
        i_rpes_radio_model.level(B_BUSY, 1'b1);
        wr(IDX_CTRL, 32'h08);
        cyc(1200);
        rd_chk(IDX_STAT, 32'h0, "cca early");
        cyc(150);
        check({31'h0, cca_result}, 32'h1, "cca busy");
        rd_chk(IDX_CTRL, 32'h100, "cca result bit");
        rd_chk(IDX_STAT, 32'h40000, "cca normal");
        cyc(2);
        check({31'h0, cca_result}, 32'h0, "cca result clear");
        wr(IDX_CTRL, 32'h0c);
        cyc(700);
        check({31'h0, cca_result}, 32'h1, "cca idle busy result");
        rd_chk(IDX_STAT, 32'h40000, "cca idle busy");
        i_rpes_radio_model.level(B_BUSY, 1'b0);
        wr(IDX_CTRL, 32'h0c);
        cyc(700);
        rd_chk(IDX_STAT, 32'h0, "cca idle wait");
        cyc(650);
        rd_chk(IDX_STAT, 32'h40000, "cca idle");
        check({31'h0, cca_result}, 32'h0, "cca idle result");
        $display("test cca done");

        wr(IDX_GTCLK, 32'h4);
        wr(IDX_GT1, 32'h5);
        wr(IDX_GT2, 32'h14);
        wr(IDX_CTRL, 32'h30);
        cyc(28);
        rd_chk(IDX_STAT, 32'h400000, "timer one");
        cyc(70);
        rd_chk(IDX_STAT, 32'h800000, "timer two");
        $display("test timers done");
        complete_run();
    end
endmodule
